// file: logic/pin_sync.sv
// three-stage pin synchroniser; changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin,
   output var  logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg;
   logic [WIDTH-1:0] level_next;
   initial begin
      if (WIDTH < 1) $error("pin_sync width");
   end
   always_comb begin
      level_next = level_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) level_next[i] = s2_reg[i];
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         level_reg <= '0;
      end else begin
         s1_reg    <= pin;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end
   assign level = level_reg;
endmodule : pin_sync
`default_nettype wire

// file: logic/sar_converter.sv
// converter end: successive approximation sequencer with three-state outputs
//
// Notes on behaviour
// - start mid-conversion aborts at next clock; here it aborts five clocks after start rises, past the four-flop synchroniser
// - start returns low, fresh sequence begins
// - start held high keeps resetting to MSB
// - tied controls drive all twelve together
// - truncate high runs twelve decisions
// - result held from done until next start
// - host reads nibble and byte separately
// - upper nibble stays on data lines eleven to eight
// - receiver samples serial bit on strobe rise
// - floating strobe reads as high
// - top address bit selects converter
// - start address nibble makes start pulse
// - start, done, low byte addresses used
// - host polls done bit zero first
// - low byte and nibble at adjacent addresses
// - host stretches commands to 500 ns
// - done rises with final decision
// - truncate low ends after eight decisions
// - start rise sets MSB, clears done
// - strobe floats one clock after done
`timescale 1ns/1ps
`default_nettype none
module sar_converter
   import sar_pkg::*;
#(
   parameter int BITS  = RESULT_BITS,
   parameter int SHORT = SHORT_BITS
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   sar_link_if.converter link
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_HOLD,
      ST_RUN,
      ST_TAIL
   } conv_state_t;
   // the output map splits a twelve-bit word into a nibble and a byte group
   initial begin
      if (BITS != 12) $error("sar_converter width must be twelve");
      if (SHORT < 1 || SHORT > BITS) $error("sar_converter truncation out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // input pins pass four flops before use: three stages and the agreement register
   logic [5:0] pins;
   pin_sync #(.WIDTH(6)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   ({link.start, link.low_byte_output_control, link.high_nibble_output_control,
               link.done_flag_output_control, link.truncate_select, link.comparator}),
      .level (pins)
   );
   logic start_s, low_ctl, high_ctl, done_ctl, trunc_s, comp_s;
   assign {start_s, low_ctl, high_ctl, done_ctl, trunc_s, comp_s} = pins;

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   conv_state_t      state_reg, state_next;
   logic [BITS-1:0]  sar_reg, sar_next;
   logic [BITS-1:0]  trial_reg, trial_next;
   logic             done_reg, done_next;
   logic             ser_reg, ser_next;
   logic             ser_oe_reg, ser_oe_next;
   logic             strobe_reg, strobe_next;
   logic [BITS-1:0]  last_trial;
   logic [BITS-1:0]  kept_word;

   ////////////////////////////////////////////////////////////////////////
   // trial helpers, shared by restart and by every decision

   // the word a start parks the register on: msb under trial, rest clear
   function automatic logic [BITS-1:0] msb_trial();
      msb_trial = {1'b1, {(BITS-1){1'b0}}};
   endfunction : msb_trial

   // comparator high means input below trial: drop the bit
   function automatic logic [BITS-1:0] decide(input logic [BITS-1:0] word,
                                              input logic [BITS-1:0] trial,
                                              input logic            comp);
      decide = comp ? (word & ~trial) : word;
   endfunction : decide

   // the last bit under trial depends on truncation, latched each start
   logic             trunc_reg, trunc_next;
   assign last_trial = trunc_reg ? {{(BITS-1){1'b0}}, 1'b1}
                                 : ({{(BITS-1){1'b0}}, 1'b1} << (BITS - SHORT));
   assign kept_word  = decide(sar_reg, trial_reg, comp_s);

   always_comb begin
      state_next  = state_reg;
      sar_next    = sar_reg;
      trial_next  = trial_reg;
      done_next   = done_reg;
      ser_next    = ser_reg;
      ser_oe_next = ser_oe_reg;
      strobe_next = 1'b0;
      trunc_next  = trunc_reg;
      if (start_s) begin
         // restart wins over any sequence in flight
         state_next  = ST_HOLD;
         sar_next    = msb_trial();
         trial_next  = msb_trial();
         done_next   = 1'b0;
         ser_oe_next = 1'b1;
         trunc_next  = trunc_s;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               ser_oe_next = 1'b0;
            end
            ST_HOLD: begin
               state_next = ST_RUN;
            end
            ST_RUN: begin
               // a decision spans two clocks, strobe high then low, so every bit
               // gets a rising strobe edge of its own; costs twice the clocks per bit
               if (!strobe_reg) begin
                  sar_next    = kept_word;
                  ser_next    = ~comp_s;
                  strobe_next = 1'b1;
                  if (trial_reg == last_trial) begin
                     done_next  = 1'b1;
                     state_next = ST_TAIL;
                  end else begin
                     trial_next = trial_reg >> 1;
                     sar_next   = kept_word | (trial_reg >> 1);
                  end
               end
            end
            ST_TAIL: begin
               // strobe is still high here and floats as it drops, so no new rise
               ser_oe_next = 1'b0;
               state_next  = ST_IDLE;
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer registers; reset parks it idle with serial outputs floating
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= ST_IDLE;
         sar_reg    <= '0;
         trial_reg  <= '0;
         done_reg   <= 1'b0;
         ser_reg    <= 1'b0;
         ser_oe_reg <= 1'b0;
         strobe_reg <= 1'b0;
         trunc_reg  <= 1'b1;
      end else begin
         state_reg  <= state_next;
         sar_reg    <= sar_next;
         trial_reg  <= trial_next;
         done_reg   <= done_next;
         ser_reg    <= ser_next;
         ser_oe_reg <= ser_oe_next;
         strobe_reg <= strobe_next;
         trunc_reg  <= trunc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // three-state enables; result word changes on start and on each decision
   logic low_oe_reg, high_oe_reg, done_oe_reg;
   logic low_oe_next, high_oe_next, done_oe_next;
   // enables lag the controls by the synchroniser plus this register
   always_comb begin
      low_oe_next  = low_ctl;
      high_oe_next = high_ctl;
      done_oe_next = done_ctl;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         low_oe_reg  <= 1'b0;
         high_oe_reg <= 1'b0;
         done_oe_reg <= 1'b0;
      end else begin
         low_oe_reg  <= low_oe_next;
         high_oe_reg <= high_oe_next;
         done_oe_reg <= done_oe_next;
      end
   end
   assign link.data_out          = sar_reg;
   assign link.low_oe            = low_oe_reg;
   assign link.high_oe           = high_oe_reg;
   assign link.done_out          = done_reg;
   assign link.done_oe           = done_oe_reg;
   assign link.serial_result_bit = ser_reg;
   assign link.serial_oe         = ser_oe_reg;
   assign link.strobe_out        = strobe_reg;
   assign link.strobe_oe         = ser_oe_reg;
endmodule : sar_converter
`default_nettype wire

// file: logic/sar_host.sv
// host end: Avalon-MM slave that turns register accesses into converter commands
`timescale 1ns/1ps
`default_nettype none
module sar_host
   import sar_pkg::*;
#(
   parameter int HOLD_CYC = STROBE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   output var  logic [7:0]  serial_word,
   sar_link_if.host link
);
   typedef enum logic [1:0] {
      H_IDLE,
      H_STROBE,
      H_DONE
   } host_state_t;
   initial begin
      if (HOLD_CYC < 1 || HOLD_CYC > 255) $error("sar_host hold");
   end

   // map an op to its memory-style address: top bit selects, nibble commands
   function automatic logic [15:0] op_addr(input host_op_t op);
      case (op)
         OP_START: op_addr = CSEL_MASK | {12'h000, NIB_START};
         OP_DONE:  op_addr = CSEL_MASK | {12'h000, NIB_DONE};
         OP_LOW:   op_addr = CSEL_MASK | {12'h000, NIB_LOW};
         default:  op_addr = CSEL_MASK | {12'h000, NIB_HIGH};
      endcase
   endfunction : op_addr

   host_state_t state_reg, state_next;
   host_op_t    op_reg, op_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic [15:0] bus_addr_reg, bus_addr_next;
   logic [31:0] rd_reg, rd_next;
   logic        wait_reg, wait_next;
   logic        trunc_reg, trunc_next;
   logic [7:0]  ser_reg, ser_next;
   logic        strobe_d_reg;
   logic        strobe_seen;

   // floating strobe reads high, so no false rise after the last bit
   assign strobe_seen = link.strobe_oe ? link.strobe_out : 1'b1;

   always_comb begin
      state_next    = state_reg;
      op_next       = op_reg;
      cnt_next      = cnt_reg;
      bus_addr_next = bus_addr_reg;
      rd_next       = rd_reg;
      wait_next     = 1'b1;
      trunc_next    = trunc_reg;
      ser_next      = ser_reg;
      if (strobe_seen && !strobe_d_reg)
         ser_next = {ser_reg[6:0], link.serial_result_bit};
      case (state_reg)
         H_IDLE: begin
            if (write && address == AV_CTRL) begin
               trunc_next = writedata[0];
               wait_next  = 1'b0;
               // answered now; the pass through H_DONE keeps the held request from being taken twice
               state_next = H_DONE;
               if (writedata[1]) begin
                  op_next   = OP_START;
                  wait_next = 1'b1;
                  state_next = H_STROBE;
                  cnt_next  = HOLD_CYC[7:0];
               end
            end else if (read && address == AV_STATUS) begin
               op_next    = OP_DONE;
               state_next = H_STROBE;
               cnt_next   = HOLD_CYC[7:0];
            end else if (read && address == AV_RESULT) begin
               op_next    = OP_LOW;
               state_next = H_STROBE;
               cnt_next   = HOLD_CYC[7:0];
            end else if (read || write) begin
               rd_next    = (read && address == AV_CTRL) ? {31'h00000000, trunc_reg} : UNMAPPED_DATA;
               wait_next  = 1'b0;
               state_next = H_DONE;
            end
            bus_addr_next = op_addr(op_next);
         end
         H_STROBE: begin
            // command held for at least the minimum strobe width
            if (cnt_reg > 8'h01) cnt_next = cnt_reg - 8'h01;
            else begin
               cnt_next = 8'h00;
               case (op_reg)
                  OP_START: begin
                     state_next = H_DONE;
                     wait_next  = 1'b0;
                  end
                  OP_DONE: begin
                     rd_next    = {31'h00000000, link.done_out};
                     state_next = H_DONE;
                     wait_next  = 1'b0;
                  end
                  OP_LOW: begin
                     rd_next[7:0] = link.data_out[7:0];
                     op_next      = OP_HIGH;
                     cnt_next     = HOLD_CYC[7:0];
                     bus_addr_next = op_addr(OP_HIGH);
                  end
                  default: begin
                     rd_next    = {16'h0000, 4'h0, link.data_out[11:8], rd_reg[7:0]};
                     state_next = H_DONE;
                     wait_next  = 1'b0;
                  end
               endcase
            end
         end
         H_DONE: begin
            state_next    = H_IDLE;
            bus_addr_next = 16'h0000;
         end
         default: state_next = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= H_IDLE;
         op_reg       <= OP_START;
         cnt_reg      <= 8'h00;
         bus_addr_reg <= 16'h0000;
         rd_reg       <= 32'h00000000;
         wait_reg     <= 1'b1;
         trunc_reg    <= CTRL_RESET[0];
         ser_reg      <= 8'h00;
         strobe_d_reg <= 1'b1;
      end else begin
         state_reg    <= state_next;
         op_reg       <= op_next;
         cnt_reg      <= cnt_next;
         bus_addr_reg <= bus_addr_next;
         rd_reg       <= rd_next;
         wait_reg     <= wait_next;
         trunc_reg    <= trunc_next;
         ser_reg      <= ser_next;
         strobe_d_reg <= strobe_seen;
      end
   end

   // decode of the held command address into converter strobes
   logic active;
   assign active = (state_reg == H_STROBE) && bus_addr_reg[15];
   assign link.start                      = active && bus_addr_reg[3:0] == NIB_START;
   assign link.done_flag_output_control   = active && bus_addr_reg[3:0] == NIB_DONE;
   assign link.low_byte_output_control    = active && bus_addr_reg[3:0] == NIB_LOW;
   assign link.high_nibble_output_control = active && bus_addr_reg[3:0] == NIB_HIGH;
   assign link.truncate_select            = trunc_reg;
   assign readdata    = rd_reg;
   assign waitrequest = wait_reg;
   assign serial_word = ser_reg;
endmodule : sar_host
`default_nettype wire

// file: logic/sar_link_if.sv
// interface: pins between converter and host
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
   logic        start;
   logic        low_byte_output_control;
   logic        high_nibble_output_control;
   logic        done_flag_output_control;
   logic        truncate_select;
   logic        comparator;
   logic [11:0] data_out;
   logic        low_oe;
   logic        high_oe;
   logic        done_out;
   logic        done_oe;
   logic        serial_result_bit;
   logic        serial_oe;
   logic        strobe_out;
   logic        strobe_oe;
   modport converter (
      input  start, low_byte_output_control, high_nibble_output_control,
             done_flag_output_control, truncate_select, comparator,
      output data_out, low_oe, high_oe, done_out, done_oe,
             serial_result_bit, serial_oe, strobe_out, strobe_oe
   );
   modport host (
      output start, low_byte_output_control, high_nibble_output_control,
             done_flag_output_control, truncate_select,
      input  data_out, low_oe, high_oe, done_out, done_oe,
             serial_result_bit, serial_oe, strobe_out, strobe_oe
   );
endinterface : sar_link_if
`default_nettype wire

// file: logic/sar_pkg.sv
// package: constants and types shared by both ends of the converter link
package sar_pkg;
   localparam int          RESULT_BITS     = 12;
   localparam int          SHORT_BITS      = 8;
   localparam int          ADDR_BITS       = 16;
   localparam logic [15:0] CSEL_MASK       = 16'h8000;
   localparam logic [3:0]  NIB_START       = 4'h8;
   localparam logic [3:0]  NIB_DONE        = 4'h4;
   localparam logic [3:0]  NIB_LOW         = 4'h1;
   localparam logic [3:0]  NIB_HIGH        = 4'h2;
   localparam int          MCLK_NS         = 50;
   localparam int          STROBE_MIN_NS   = 500;
   localparam int          STROBE_CYC      = (STROBE_MIN_NS + MCLK_NS - 1) / MCLK_NS;
   localparam logic [1:0]  AV_CTRL         = 2'h0;
   localparam logic [1:0]  AV_STATUS       = 2'h1;
   localparam logic [1:0]  AV_RESULT       = 2'h2;
   localparam logic [31:0] CTRL_RESET      = 32'h00000001;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
   typedef enum logic [1:0] {
      OP_START,
      OP_DONE,
      OP_LOW,
      OP_HIGH
   } host_op_t;
endpackage : sar_pkg

// file: test/sar_link_sva.sv
// checker: timing relations on the converter link
`timescale 1ns/1ps
`default_nettype none
module sar_link_sva (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        start,
   input wire logic        low_byte_output_control,
   input wire logic        high_nibble_output_control,
   input wire logic        truncate_select,
   input wire logic [11:0] data_out,
   input wire logic        low_oe,
   input wire logic        high_oe,
   input wire logic        done_out,
   input wire logic        serial_oe,
   input wire logic        strobe_out,
   input wire logic        strobe_oe
);
   logic [3:0] strobe_cnt_reg;
   logic [3:0] strobe_cnt_next;
   ////////////////////////////////////////////////////////////////////////////
   // decisions since the last start; start clears it so an abort restarts the count
   always_comb begin
      strobe_cnt_next = strobe_cnt_reg;
      if (start) begin
         strobe_cnt_next = 4'h0;
      end else if (strobe_out) begin
         strobe_cnt_next = strobe_cnt_reg + 4'h1;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_cnt_reg <= 4'h0;
      end else begin
         strobe_cnt_reg <= strobe_cnt_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // long enough to cover the four-flop start synchroniser
   sequence start_held_s;
      start [*8];
   endsequence
   sequence done_edge_s;
      $rose(done_out);
   endsequence
   // controls pass the synchroniser and the enable register before the group drives
   sequence low_on_s;
      low_byte_output_control [*6];
   endsequence
   sequence high_on_s;
      high_nibble_output_control [*6];
   endsequence
   held_reset_a: assert property (start_held_s |-> data_out == 12'h800 && !done_out && serial_oe)
      else $error("held start did not park on msb trial");
   held_still_a: assert property (start_held_s |-> !strobe_out)
      else $error("sequence advanced while start high");
   start_enable_a: assert property ($rose(start) |-> ##[1:8] serial_oe)
      else $error("serial outputs not enabled after start");
   done_strobe_a: assert property (done_edge_s |-> strobe_out)
      else $error("done rose without final decision");
   decision_count_a: assert property (done_edge_s |->
      (strobe_cnt_reg + 4'(strobe_out)) == (truncate_select ? 4'hC : 4'h8))
      else $error("wrong number of decisions");
   strobe_float_a: assert property (done_edge_s |-> serial_oe ##1 !serial_oe && !strobe_oe)
      else $error("strobe not released one clock after done");
   strobe_window_a: assert property (strobe_out |-> strobe_oe && !done_out || $rose(done_out))
      else $error("strobe outside sequence");
   result_hold_a: assert property (done_out && $past(done_out) |-> $stable(data_out))
      else $error("result moved while done");
   low_group_a: assert property (low_on_s |-> low_oe)
      else $error("low group not driven");
   high_group_a: assert property (high_on_s |-> high_oe)
      else $error("high group not driven");
endmodule : sar_link_sva
`default_nettype wire

// file: test/tb_sar_adc_output_control.sv
// testbench: both link ends joined, driven over the register bus
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_output_control;
   import sar_pkg::*;
   logic        mclk;
   logic        rst_n;
   logic [1:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [7:0]  serial_word;
   logic [31:0] rd;
   int          fails;
   int          comparisons;
   sar_link_if link_bus ();
   sar_converter sar_converter_inst (.mclk(mclk), .rst_n(rst_n), .link(link_bus.converter));
   sar_host sar_host_inst (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .serial_word(serial_word), .link(link_bus.host));
   sar_link_sva sar_link_sva_inst (.mclk(mclk), .rst_n(rst_n), .start(link_bus.start),
      .low_byte_output_control(link_bus.low_byte_output_control),
      .high_nibble_output_control(link_bus.high_nibble_output_control),
      .truncate_select(link_bus.truncate_select), .data_out(link_bus.data_out),
      .low_oe(link_bus.low_oe), .high_oe(link_bus.high_oe), .done_out(link_bus.done_out),
      .serial_oe(link_bus.serial_oe), .strobe_out(link_bus.strobe_out), .strobe_oe(link_bus.strobe_oe));
   ////////////////////////////////////////////////////////////////////////////
   always #25 mclk = ~mclk;
   task automatic close_out();
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one bus cycle; an edge passes first so strobes never change twice in one step
   task automatic av_xfer(input logic [1:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      address   <= a;
      write     <= w;
      read      <= !w;
      writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 400);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      if (n >= 400) begin
         fails++;
         close_out();
      end
   endtask : av_xfer
   // host polls the done bit, never reading the result early
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         av_xfer(AV_STATUS, 1'b0, 32'h00000000);
         n++;
      end while (rd[0] !== 1'b1 && n < 100);
      if (n >= 100) begin
         fails++;
         close_out();
      end
   endtask : wait_done
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      address = 2'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h00000000;
      link_bus.comparator = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      check("waitrequest idle", {31'h0, waitrequest}, 32'h00000001);
      av_xfer(AV_CTRL, 1'b0, 32'h00000000);
      check("ctrl reset", rd, CTRL_RESET);
      av_xfer(2'h3, 1'b1, 32'hFFFFFFFF);
      av_xfer(2'h3, 1'b0, 32'h00000000);
      check("unmapped read", rd, UNMAPPED_DATA);
      av_xfer(AV_CTRL, 1'b0, 32'h00000000);
      check("ctrl untouched", rd, CTRL_RESET);
      // full twelve decisions, every trial kept
      av_xfer(AV_CTRL, 1'b1, 32'h00000003);
      wait_done();
      av_xfer(AV_RESULT, 1'b0, 32'h00000000);
      check("result all kept", rd, 32'h00000FFF);
      check("serial all kept", {24'h0, serial_word}, 32'h000000FF);
      // abort mid-conversion; the fresh run must see only cleared trials
      av_xfer(AV_CTRL, 1'b1, 32'h00000003);
      repeat (6) @(posedge mclk);
      link_bus.comparator <= 1'b1;
      av_xfer(AV_CTRL, 1'b1, 32'h00000003);
      wait_done();
      av_xfer(AV_RESULT, 1'b0, 32'h00000000);
      check("result after abort", rd, 32'h00000000);
      check("serial after abort", {24'h0, serial_word}, 32'h00000000);
      // truncated run stops after eight decisions
      link_bus.comparator <= 1'b0;
      av_xfer(AV_CTRL, 1'b1, 32'h00000002);
      wait_done();
      av_xfer(AV_RESULT, 1'b0, 32'h00000000);
      check("result truncated", rd, 32'h00000FF0);
      check("serial truncated", {24'h0, serial_word}, 32'h000000FF);
      link_bus.comparator <= 1'b1;
      repeat (20) @(posedge mclk);
      av_xfer(AV_RESULT, 1'b0, 32'h00000000);
      check("result held", rd, 32'h00000FF0);
      av_xfer(AV_CTRL, 1'b0, 32'h00000000);
      check("ctrl truncate", rd, 32'h00000000);
      close_out();
   end
endmodule : tb_sar_adc_output_control
`default_nettype wire
